// ===== verilog/ptg_tickle_gen.sv
`default_nettype none
// Operation
// RULE1 - measure on time over sliding 200 us
// RULE2 - on time above preset: no tickle
// RULE3 - on time below preset: insert tickle
// RULE4 - off gap over 200 us: tickle
// RULE5 - tickle lasts fixed two to six us
// RULE6 - no prediction; command merges with tickle
// RULE7 - command high means beam on
// RULE8 - accept DC up to 160 kHz
// RULE9 - drive follows duty, 0 to 100 percent
// RULE10 - controller default 5 kHz base rate
// RULE11 - steady high gives continuous drive
// RULE12 - controller limits duty to 95 percent
// RULE13 - controller gates by pulse timing
// RULE14 - higher rates for ripple-free motion
// RULE15 - two-stage synchroniser on command input
// RULE16 - threshold and length fixed in cycles
// RULE17 - drive is command OR tickle
module ptg_tickle_gen #(
	parameter int unsigned WINDOW_CYC = ptg_pkg::WINDOW_CYC
) (
	input  wire logic clk_in,
	input  wire logic rst_in,
	input  wire logic cmd_in,
	output logic      drive_en_out,
	output logic      tickle_out,
	output logic      on_time_ok_out
);
	logic                      cmd_s;
	logic [WINDOW_CYC-1:0]     hist_q;
	logic [ptg_pkg::CNT_W-1:0] on_cnt_q;
	logic [ptg_pkg::CNT_W-1:0] on_cnt_d;
	logic [ptg_pkg::CNT_W-1:0] gap_q;
	logic [ptg_pkg::LEN_W-1:0] tick_q;
	logic                      tick_start;
	logic                      ok;
	logic                      gap_full;
	logic                      tick_act;
	logic                      drive_d;

	ptg_sync u_sync (  // see RULE15 see RULE8
		.clk_in (clk_in),
		.rst_in (rst_in),
		.d_in   (cmd_in),
		.q_out  (cmd_s)
	);

	// drive level of this cycle; tickles count too, so one tickle per window suffices
	assign drive_d  = cmd_s | tick_start | tick_act; // see RULE17 see RULE6
	// window sum: add newest sample, drop the one leaving
	assign on_cnt_d = on_cnt_q + (drive_d ? ptg_pkg::CNT_ONE : ptg_pkg::CNT_ZERO)
		- (hist_q[WINDOW_CYC-1] ? ptg_pkg::CNT_ONE : ptg_pkg::CNT_ZERO); // see RULE1
	assign ok       = on_cnt_q > ptg_pkg::CNT_W'(ptg_pkg::TICKLE_THR_CYC); // see RULE2 see RULE16
	assign gap_full = gap_q >= ptg_pkg::CNT_W'(WINDOW_CYC); // see RULE4
	assign tick_act = tick_q != ptg_pkg::LEN_ZERO;
	// no look-ahead: start only from past window state
	assign tick_start = !tick_act && !cmd_s && (!ok || gap_full); // see RULE3 see RULE6

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			hist_q <= '0;
		end else begin
			hist_q <= {hist_q[WINDOW_CYC-2:0], drive_d}; // see RULE1
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			on_cnt_q <= ptg_pkg::CNT_ZERO;
		end else begin
			on_cnt_q <= on_cnt_d; // see RULE9
		end
	end

	// off-time counter, cleared by command and by each tickle
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			gap_q <= ptg_pkg::CNT_ZERO;
		end else if (cmd_s || tick_start) begin
			gap_q <= ptg_pkg::CNT_ZERO;
		end else if (!gap_full) begin
			gap_q <= gap_q + ptg_pkg::CNT_ONE;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			tick_q <= ptg_pkg::LEN_ZERO;
		end else if (tick_start) begin
			tick_q <= ptg_pkg::LEN_W'(ptg_pkg::TICKLE_LEN_CYC); // see RULE5 see RULE16
		end else if (tick_act) begin
			tick_q <= tick_q - ptg_pkg::LEN_ONE;
		end
	end

	// drive: high level passes straight through, incl. constant high
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			drive_en_out   <= 1'b0;
			tickle_out     <= 1'b0;
			on_time_ok_out <= 1'b0;
		end else begin
			drive_en_out   <= drive_d; // see RULE17 see RULE7 see RULE11
			tickle_out     <= tick_start | tick_act;
			on_time_ok_out <= ok;
		end
	end
endmodule // ptg_tickle_gen
`default_nettype wire

// ===== verilog/ptg_pkg.sv
`default_nettype none
package ptg_pkg;
	localparam int unsigned CLK_MHZ          = 100;
	localparam int unsigned WINDOW_US        = 200;
	localparam int unsigned WINDOW_CYC       = WINDOW_US * CLK_MHZ;
	localparam int unsigned TICKLE_ON_NS     = 4000;
	localparam int unsigned TICKLE_LEN_CYC   = (TICKLE_ON_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned TICKLE_THR_CYC   = TICKLE_LEN_CYC;
	localparam int unsigned CNT_W            = 15;
	localparam int unsigned LEN_W            = 10;
	localparam logic [CNT_W-1:0] CNT_ZERO    = 15'h0000;
	localparam logic [CNT_W-1:0] CNT_ONE     = 15'h0001;
	localparam logic [LEN_W-1:0] LEN_ZERO    = 10'h000;
	localparam logic [LEN_W-1:0] LEN_ONE     = 10'h001;
endpackage
`default_nettype wire

// ===== verilog/ptg_sync.sv
`default_nettype none
module ptg_sync (
	input  wire logic clk_in,
	input  wire logic rst_in,
	input  wire logic d_in,
	output logic      q_out
);
	logic meta_q;
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			meta_q <= 1'b0;
			q_out  <= 1'b0;
		end else begin
			meta_q <= d_in;
			q_out  <= meta_q;
		end
	end
endmodule // ptg_sync
`default_nettype wire

// ===== tb/ptg_chk_checker.sv
`default_nettype none
module ptg_chk (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic cmd_in,
	input wire logic drive_en_out,
	input wire logic tickle_out,
	input wire logic on_time_ok_out
);
	timeunit 1ns; timeprecision 1ns;
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	localparam int TICK_HI  = ptg_pkg::TICKLE_LEN_CYC + 1;
	localparam int DARK_MAX = ptg_pkg::WINDOW_CYC + 4;
	int tl_q;
	int dark_q;
	// run length of tickle high and of drive low
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			tl_q   <= 0;
			dark_q <= 0;
		end else begin
			tl_q   <= tickle_out ? tl_q + 1 : 0;
			dark_q <= drive_en_out ? 0 : dark_q + 1;
		end
	end
	a_tick_len: assert property ($fell(tickle_out) |-> tl_q == TICK_HI)
		else $error("tickle length wrong");
	a_gap_tick: assert property (dark_q <= DARK_MAX)
		else $error("drive off too long");
	a_tick_drive: assert property (tickle_out |-> drive_en_out) else $error("drive low");
	a_cmd_drive: assert property (cmd_in |-> ##3 drive_en_out) else $error("no drive");
	a_idle_tick: assert property (!cmd_in[*4] ##0 !on_time_ok_out |-> ##[0:4] tickle_out)
		else $error("no tickle");
	a_ok_quiet: assert property (on_time_ok_out[*3] |-> !$rose(tickle_out))
		else $error("extra tickle");
	cover property ($fell(tickle_out));
	cover property (on_time_ok_out);
	cover property (cmd_in && tickle_out);
endmodule // ptg_chk
bind ptg_tickle_gen ptg_chk chk_u (.clk_in(clk_in), .rst_in(rst_in), .cmd_in(cmd_in),
	.drive_en_out(drive_en_out), .tickle_out(tickle_out), .on_time_ok_out(on_time_ok_out));
`default_nettype wire

// ===== tb/ptg_ctl.sv
`default_nettype none
module ptg_ctl (
	input  wire logic [31:0] hi_in,
	input  wire logic [31:0] per_in,
	input  wire logic        clk_in,
	output logic             cmd_out = 1'b0
);
	timeunit 1ns; timeprecision 1ns;
	int c = 0;
	always @(negedge clk_in) begin
		c = (c >= per_in - 1) ? 0 : c + 1;
		cmd_out <= c < hi_in;
	end
endmodule // ptg_ctl
`default_nettype wire

// ===== tb/tb.sv
`default_nettype none
module tb;
	timeunit 1ns; timeprecision 1ns;
	localparam int WIN = ptg_pkg::WINDOW_CYC;
	localparam int THR = ptg_pkg::TICKLE_THR_CYC;
	localparam int LEN = ptg_pkg::TICKLE_LEN_CYC;
	logic        clk_in = 1'b0, rst_in = 1'b1, cmd, drv, tck, ok;
	logic        e_drv = 1'b0, e_tck = 1'b0, e_ok = 1'b0;
	logic [31:0] x = 32'hFA58, hi = 32'h0, per = 32'h271;
	int          n_mismatch = 0, checked = 0, sum = 0, tl = 0, nt = 0, q[$];
	int          m1 = 0, m2 = 0, mt = 0, mg = 0, d = 0;
	bit          m_act, m_ok, m_start;
	always #5 clk_in = ~clk_in;
	ptg_ctl c_u (.clk_in(clk_in), .hi_in(hi), .per_in(per), .cmd_out(cmd));
	ptg_tickle_gen dut_u (.clk_in(clk_in), .rst_in(rst_in), .cmd_in(cmd), .drive_en_out(drv),
		.tickle_out(tck), .on_time_ok_out(ok));
	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] r;
		r = v ^ (v << 13);
		r = r ^ (r >> 17);
		r = r ^ (r << 5);
		return r;
	endfunction
	task chk(string s, logic v, logic e);
		checked++;
		if (v !== e) $display("MISMATCH %s exp %b seen %b", s, e, v);
		n_mismatch += int'(v !== e);
	endtask
	task give_verdict(int extra);
		n_mismatch += extra;
		$display("checked %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	always @(posedge clk_in) if (!rst_in) begin
		chk("ok", ok, e_ok);
		chk("drive", drv, e_drv);
		chk("tickle", tck, e_tck);
		if (!tck && tl > 0) chk("tlen", tl == LEN + 1, 1'b1);
		nt += int'(tck && tl == 0);
		tl = tck ? tl + 1 : 0;
		// model: two-stage sync, window of drive, off-time count, tickle timer
		m_act = mt > 0;
		m_ok = sum > THR;
		m_start = !m_act && m2 == 0 && (!m_ok || mg >= WIN);
		d = m2 | int'(m_start) | int'(m_act);
		q.push_back(d);
		sum += d - (q.size() > WIN ? q.pop_front() : 0);
		mg = (m2 != 0 || m_start) ? 0 : (mg >= WIN ? mg : mg + 1);
		mt = m_start ? LEN : (m_act ? mt - 1 : 0);
		e_drv = d != 0;
		e_tck = m_start || m_act;
		e_ok = m_ok;
		m2 = m1;
		m1 = int'(cmd);
	end
	initial begin
		repeat (3) @(negedge clk_in);
		rst_in = 1'b0;
		for (int i = 0; i < 4; i++) begin
			x = xs(x);
			per = i == 3 ? 32'h4E20 : 32'h271;
			hi = i == 1 ? 32'h271 : i == 2 ? x % 32'h252 : i == 3 ? 32'h2 : 32'h0;
			repeat (1000) @(negedge clk_in);
			nt = 0;
			repeat (19300) @(negedge clk_in);
			if (i != 2) chk("tick", nt > 0, i != 1);
		end
		give_verdict(0);
	end
	initial #1000000 give_verdict(1);
endmodule // tb
`default_nettype wire
